// [logic/adc_port_pkg.sv]
// constants and types of the converter serial register port
package adc_port_pkg;


// ----------------------------------------
// register addresses
// ----------------------------------------
localparam logic [2:0] ADDR_CMD_STAT = 3'h0;
localparam logic [2:0] ADDR_MODE = 3'h1;
localparam logic [2:0] ADDR_CFG = 3'h2;
localparam logic [2:0] ADDR_DATA = 3'h3;
localparam logic [2:0] ADDR_ID = 3'h4;
localparam logic [2:0] ADDR_GPO = 3'h5;
localparam logic [2:0] ADDR_OFS = 3'h6;
localparam logic [2:0] ADDR_GAIN = 3'h7;

// ----------------------------------------
// reset values
// ----------------------------------------
localparam logic [7:0] STAT_RESET = 8'h80;
localparam logic [23:0] MODE_RESET = 24'h08_0060;
localparam logic [23:0] CFG_RESET = 24'h00_0117;
localparam logic [23:0] DATA_RESET = 24'h00_0000;
localparam logic [7:0] GPO_RESET = 8'h00;
localparam logic [23:0] OFS_RESET = 24'h80_0000;
// middle digits are factory trimmed, low and high digits fixed
localparam logic [23:0] GAIN_RESET = 24'h50_0000;
// arbitrary identification value
localparam logic [7:0] PART_ID = 8'h5A;

// ----------------------------------------
// command byte fields and codes
// ----------------------------------------
localparam int CMD_DIR_BIT = 6;
localparam int CMD_SEL_HI = 5;
localparam int CMD_SEL_LO = 3;
localparam int CMD_CONT_BIT = 2;
localparam logic [7:0] CMD_CONT_ENTER = 8'h5C;
localparam logic [7:0] CMD_CONT_EXIT = 8'h58;

// ----------------------------------------
// register field positions
// ----------------------------------------
localparam int MODE_APPEND_BIT = 20;
localparam int MODE_PARITY_EN_BIT = 13;

// ----------------------------------------
// shift lengths and counts
// ----------------------------------------
localparam logic [5:0] LEN_BYTE = 6'h08;
localparam logic [5:0] LEN_WORD = 6'h18;
localparam logic [5:0] LEN_LONG = 6'h20;
localparam logic [5:0] CMD_LAST = 6'h07;
localparam logic [5:0] ONES_RESET = 6'h28;

// ----------------------------------------
// types
// ----------------------------------------
typedef struct packed {
   logic [23:0] data;
   logic [2:0] chan;
   logic err;
   logic noref;
} conv_result_t;

typedef struct packed {
   logic [2:0] addr;
   logic [23:0] word;
} reg_write_t;

typedef enum logic [1:0] {
   ST_CMD,
   ST_WR,
   ST_RD,
   ST_CONT
} port_state_t;

endpackage

// [logic/bit_sync.sv]
// three-stage level synchroniser with agreement filter
`timescale 1ns/100ps
module bit_sync (
   // destination clock
   input wire logic clock,
   // level from another domain
   input wire logic d,
   // filtered level
   output logic q
);

   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic q_r;

   // ----------------------------------------
   // three-flop chain
   // ----------------------------------------
   always_ff @(posedge clock) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
   end

   // ----------------------------------------
   // take a change once stages two and three agree
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (s2_r == s3_r) begin
         q_r <= s3_r;
      end
   end

   assign q = q_r;

endmodule // bit_sync

// [logic/adc_serial_register_port.sv]
// serial register port of the converter: link engine and register file
`timescale 1ns/100ps
module adc_serial_register_port
   import adc_port_pkg::*;
(
   // core clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // serial pins
   input wire logic sclk,
   input wire logic din,
   output logic sdo,
   // conversion results in
   input wire logic result_valid,
   input conv_result_t result,
   // register contents out
   output logic [23:0] mode_word,
   output logic [23:0] setup_word,
   output logic [7:0] switch_word,
   output logic [23:0] offset_word,
   output logic [23:0] gain_word,
   // control pulses out
   output logic restart,
   output logic part_reset
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic rst_seen;
   logic soft_rst;
   logic srst;
   port_state_t state_r;
   logic [5:0] ones_r;
   logic [5:0] cmd_cnt_r;
   logic [5:0] bit_cnt_r;
   logic [5:0] cmd_sh_r;
   logic [23:0] wr_sh_r;
   logic [2:0] sel_r;
   logic cmd_listen;
   logic cmd_done;
   logic [7:0] cmd_byte;
   logic [5:0] len;
   logic last_bit;
   logic [5:0] rd_idx;
   logic [31:0] rd_word;
   logic wr_tgl_r;
   logic rd_tgl_r;
   logic prst_tgl_r;
   reg_write_t wr_hold_r;
   logic end_tgl_r;
   logic end_ack_r;
   logic dout_r;
   logic out_active_r;
   logic wr_s;
   logic rd_s;
   logic pr_s;
   logic wr_p_r;
   logic rd_p_r;
   logic pr_p_r;
   logic wr_ev;
   logic rd_ev;
   logic prst_ev;
   logic mode_wr;
   logic [23:0] mode_r;
   logic [23:0] setup_r;
   logic [7:0] switch_r;
   logic [23:0] offset_r;
   logic [23:0] gain_r;
   logic [23:0] data_r;
   logic rdy_n_r;
   logic err_r;
   logic noref_r;
   logic parity_r;
   logic [2:0] chan_r;
   logic [7:0] status;
   logic restart_r;
   logic part_reset_r;

   // ----------------------------------------
   // read length per register
   // ----------------------------------------
   function automatic logic [5:0] reg_len(input logic [2:0] sel,
                                          input logic append);
      logic [5:0] n;
      n = LEN_WORD;
      if (sel == ADDR_CMD_STAT) begin
         n = LEN_BYTE;
      end else if (sel == ADDR_DATA) begin
         n = append ? LEN_LONG : LEN_WORD;
      end else if (sel == ADDR_ID || sel == ADDR_GPO) begin
         n = LEN_BYTE;
      end else begin
         n = LEN_WORD;
      end
      return n;
   endfunction

   // ----------------------------------------
   // link reset: core reset seen on sclk, or forty ones
   // ----------------------------------------
   bit_sync u_rst_sync (
      .clock(sclk),
      .d(rst_n),
      .q(rst_seen)
   );

   assign soft_rst = din && (ones_r == ONES_RESET - 6'h01);
   assign srst = !rst_seen || soft_rst;

   always_ff @(posedge sclk) begin
      if (!rst_seen || soft_rst) begin
         ones_r <= '0;
      end else if (din) begin
         ones_r <= ones_r + 6'h01;
      end else begin
         ones_r <= '0;
      end
   end

   always_ff @(posedge sclk) begin
      if (!rst_seen) begin
         prst_tgl_r <= 1'b0;
      end else if (soft_rst) begin
         prst_tgl_r <= !prst_tgl_r;
      end
   end

   // ----------------------------------------
   // command byte receiver
   // ----------------------------------------
   assign cmd_listen = (state_r == ST_CMD) || (state_r == ST_CONT);
   assign cmd_done = cmd_listen && (cmd_cnt_r == CMD_LAST);
   // write-gate bit is 0 by construction, msb arrives first
   assign cmd_byte = {1'b0, cmd_sh_r, din};

   always_ff @(posedge sclk) begin
      if (srst || !cmd_listen) begin
         cmd_cnt_r <= '0;
      end else if (cmd_cnt_r == 6'h00) begin
         if (!din) begin
            cmd_cnt_r <= 6'h01;
         end
      end else if (cmd_done) begin
         cmd_cnt_r <= '0;
      end else begin
         cmd_cnt_r <= cmd_cnt_r + 6'h01;
      end
   end

   always_ff @(posedge sclk) begin
      if (srst) begin
         cmd_sh_r <= '0;
      end else if (cmd_listen) begin
         cmd_sh_r <= {cmd_sh_r[4:0], din};
      end
   end

   // ----------------------------------------
   // transaction state
   // ----------------------------------------
   assign len = reg_len(sel_r, mode_r[MODE_APPEND_BIT]);
   assign last_bit = (bit_cnt_r == len - 6'h01);

   always_ff @(posedge sclk) begin
      if (srst) begin
         state_r <= ST_CMD;
      end else begin
         case (state_r)
            ST_CMD: begin
               // only a finished command byte moves the port
               if (cmd_done) begin
                  if (cmd_byte[CMD_DIR_BIT]) begin
                     if (cmd_byte[CMD_SEL_HI:CMD_SEL_LO] == ADDR_DATA &&
                         cmd_byte[CMD_CONT_BIT]) begin
                        state_r <= ST_CONT;
                     end else begin
                        state_r <= ST_RD;
                     end
                  end else if (cmd_byte[CMD_SEL_HI:CMD_SEL_LO] !=
                               ADDR_CMD_STAT) begin
                     state_r <= ST_WR;
                  end
               end
            end
            ST_WR, ST_RD: begin
               if (last_bit) begin
                  state_r <= ST_CMD;
               end
            end
            ST_CONT: begin
               if (cmd_done && cmd_byte == CMD_CONT_EXIT) begin
                  state_r <= ST_CMD;
               end
            end
            default: begin
               state_r <= ST_CMD;
            end
         endcase
      end
   end

   always_ff @(posedge sclk) begin
      if (srst) begin
         sel_r <= ADDR_CMD_STAT;
      end else if (state_r == ST_CMD && cmd_done) begin
         sel_r <= cmd_byte[CMD_SEL_HI:CMD_SEL_LO];
      end
   end

   always_ff @(posedge sclk) begin
      if (srst || state_r == ST_CMD) begin
         bit_cnt_r <= '0;
      end else if (last_bit) begin
         bit_cnt_r <= '0;
      end else begin
         bit_cnt_r <= bit_cnt_r + 6'h01;
      end
   end

   // ----------------------------------------
   // register write capture
   // ----------------------------------------
   always_ff @(posedge sclk) begin
      if (srst) begin
         wr_sh_r <= '0;
      end else if (state_r == ST_WR) begin
         wr_sh_r <= {wr_sh_r[22:0], din};
      end
   end

   always_ff @(posedge sclk) begin
      if (!rst_seen) begin
         wr_tgl_r <= 1'b0;
         wr_hold_r <= '0;
      end else if (!soft_rst && state_r == ST_WR && last_bit) begin
         wr_hold_r <= '{addr: sel_r, word: {wr_sh_r[22:0], din}};
         wr_tgl_r <= !wr_tgl_r;
      end
   end

   // data register read finished: ready goes back high unless result_valid is set in the same core cycle
   always_ff @(posedge sclk) begin
      if (!rst_seen) begin
         rd_tgl_r <= 1'b0;
      end else if (!soft_rst && sel_r == ADDR_DATA && last_bit &&
                   (state_r == ST_RD || state_r == ST_CONT)) begin
         rd_tgl_r <= !rd_tgl_r;
      end
   end

   // ----------------------------------------
   // read word, taken live from the core registers, which can change meanwhile
   // ----------------------------------------
   always_comb begin
      rd_word = '0;
      if (sel_r == ADDR_CMD_STAT) begin
         rd_word = {24'h00_0000, status};
      end else if (sel_r == ADDR_MODE) begin
         rd_word = {8'h00, mode_r};
      end else if (sel_r == ADDR_CFG) begin
         rd_word = {8'h00, setup_r};
      end else if (sel_r == ADDR_DATA) begin
         if (mode_r[MODE_APPEND_BIT]) begin
            rd_word = {data_r, status};
         end else begin
            rd_word = {8'h00, data_r};
         end
      end else if (sel_r == ADDR_ID) begin
         rd_word = {24'h00_0000, PART_ID};
      end else if (sel_r == ADDR_GPO) begin
         rd_word = {24'h00_0000, switch_r};
      end else if (sel_r == ADDR_OFS) begin
         rd_word = {8'h00, offset_r};
      end else begin
         rd_word = {8'h00, gain_r};
      end
   end

   assign rd_idx = len - 6'h01 - bit_cnt_r;

   // ----------------------------------------
   // output shifter, launched on falling sclk
   // ----------------------------------------
   always_ff @(negedge sclk) begin
      if (!rst_seen) begin
         dout_r <= 1'b1;
         out_active_r <= 1'b0;
      end else begin
         dout_r <= rd_word[rd_idx[4:0]];
         out_active_r <= (state_r == ST_RD) || (state_r == ST_CONT);
      end
   end

   // gap from last sampled bit to next falling edge shows ready
   always_ff @(posedge sclk) begin
      if (!rst_seen) begin
         end_tgl_r <= 1'b0;
      end else if (last_bit && (state_r == ST_RD || state_r == ST_CONT)) begin
         end_tgl_r <= !end_tgl_r;
      end
   end

   always_ff @(negedge sclk) begin
      if (!rst_seen) begin
         end_ack_r <= 1'b0;
      end else begin
         end_ack_r <= end_tgl_r;
      end
   end

   // ready shows under reset and as soon as the port is back at command wait
   assign sdo = (rst_n && out_active_r && state_r != ST_CMD &&
                 end_tgl_r == end_ack_r) ? dout_r : rdy_n_r;

   // ----------------------------------------
   // crossings into the core clock
   // ----------------------------------------
   bit_sync u_wr_sync (
      .clock(clock),
      .d(wr_tgl_r),
      .q(wr_s)
   );

   bit_sync u_rd_sync (
      .clock(clock),
      .d(rd_tgl_r),
      .q(rd_s)
   );

   bit_sync u_pr_sync (
      .clock(clock),
      .d(prst_tgl_r),
      .q(pr_s)
   );

   // previous values follow even in reset so no stale event fires
   always_ff @(posedge clock) begin
      wr_p_r <= wr_s;
      rd_p_r <= rd_s;
      pr_p_r <= pr_s;
   end

   assign wr_ev = rst_n && (wr_s != wr_p_r);
   assign rd_ev = rst_n && (rd_s != rd_p_r);
   assign prst_ev = rst_n && (pr_s != pr_p_r);
   assign mode_wr = wr_ev && (wr_hold_r.addr == ADDR_MODE);

   // ----------------------------------------
   // register file
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n || prst_ev) begin
         mode_r <= MODE_RESET;
         setup_r <= CFG_RESET;
         switch_r <= GPO_RESET;
         offset_r <= OFS_RESET;
         gain_r <= GAIN_RESET;
      end else if (wr_ev) begin
         if (wr_hold_r.addr == ADDR_MODE) begin
            mode_r <= wr_hold_r.word;
         end else if (wr_hold_r.addr == ADDR_CFG) begin
            setup_r <= wr_hold_r.word;
         end else if (wr_hold_r.addr == ADDR_GPO) begin
            switch_r <= wr_hold_r.word[7:0];
         end else if (wr_hold_r.addr == ADDR_OFS) begin
            offset_r <= wr_hold_r.word;
         end else if (wr_hold_r.addr == ADDR_GAIN) begin
            gain_r <= wr_hold_r.word;
         end
      end
   end

   // ----------------------------------------
   // conversion result and status
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n || prst_ev) begin
         rdy_n_r <= STAT_RESET[7];
      end else if (mode_wr) begin
         rdy_n_r <= 1'b1;
      end else if (result_valid) begin
         rdy_n_r <= 1'b0;
      end else if (rd_ev) begin
         rdy_n_r <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n || prst_ev) begin
         data_r <= DATA_RESET;
         err_r <= STAT_RESET[6];
         noref_r <= STAT_RESET[5];
         parity_r <= STAT_RESET[4];
         chan_r <= STAT_RESET[2:0];
      end else if (result_valid && !mode_wr) begin
         data_r <= result.data;
         err_r <= result.err;
         noref_r <= result.noref;
         parity_r <= mode_r[MODE_PARITY_EN_BIT] && (^result.data);
         chan_r <= result.chan;
      end
   end

   assign status = {rdy_n_r, err_r, noref_r, parity_r, 1'b0, chan_r};

   // ----------------------------------------
   // control pulses
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         restart_r <= 1'b0;
         part_reset_r <= 1'b0;
      end else begin
         restart_r <= mode_wr;
         part_reset_r <= prst_ev;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign mode_word = mode_r;
   assign setup_word = setup_r;
   assign switch_word = switch_r;
   assign offset_word = offset_r;
   assign gain_word = gain_r;
   assign restart = restart_r;
   assign part_reset = part_reset_r;

endmodule // adc_serial_register_port

// [tb/adc_port_props.sv]
// assertion checker of the converter serial register port
`timescale 1ns/100ps
module adc_port_props
   import adc_port_pkg::*;
(
   // core clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // serial pins
   input wire logic sclk,
   input wire logic din,
   input wire logic sdo,
   // conversion results
   input wire logic result_valid,
   input wire conv_result_t result,
   // register contents
   input wire logic [23:0] mode_word,
   input wire logic [23:0] setup_word,
   input wire logic [7:0] switch_word,
   input wire logic [23:0] offset_word,
   input wire logic [23:0] gain_word,
   // control pulses
   input wire logic restart,
   input wire logic part_reset
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ----------
   // cycles since the serial clock last moved
   // ----------
   logic sclk_q;
   logic [3:0] still_r;
   always_ff @(posedge clock) begin
      sclk_q <= sclk;
      if (!rst_n || sclk != sclk_q) begin
         still_r <= 4'h0;
      end else if (still_r != 4'hF) begin
         still_r <= still_r + 4'h1;
      end
   end
   // ----------
   // properties
   // ----------
   a_reset_values: assert property (disable iff (1'b0) !rst_n |=>
      mode_word == MODE_RESET && setup_word == CFG_RESET &&
      switch_word == GPO_RESET && offset_word == OFS_RESET &&
      gain_word == GAIN_RESET && !restart && !part_reset)
      else $error("outputs not at reset values");
   a_reset_ready: assert property (disable iff (1'b0) !rst_n |=> sdo)
      else $error("ready not high after reset");
   a_restart_pulse: assert property (restart |=> !restart)
      else $error("restart longer than one cycle");
   a_preset_pulse: assert property (part_reset |=> !part_reset)
      else $error("part reset longer than one cycle");
   a_preset_clears: assert property (part_reset |-> ##[0:3]
      (setup_word == CFG_RESET && mode_word == MODE_RESET))
      else $error("registers kept after part reset");
   a_regs_cause: assert property ($changed({setup_word, offset_word,
      gain_word, switch_word, mode_word}) |-> still_r < 4'hA)
      else $error("register changed without serial traffic");
   a_restart_cause: assert property (restart |-> still_r < 4'hA)
      else $error("restart without serial write");
   a_restart_ready: assert property (restart |-> ##[0:2] sdo)
      else $error("ready not set by mode write");
   a_result_ready: assert property (result_valid && still_r > 4'h9
      |=> !sdo)
      else $error("ready not low after result");
   a_ready_holds: assert property (!sdo && still_r > 4'h9 |=>
      !sdo || sclk != sclk_q)
      else $error("ready lost while idle");
   c_restart: cover property (restart);
   c_preset: cover property (part_reset);
   c_ready: cover property (result_valid ##1 !sdo);
endmodule // adc_port_props

bind adc_serial_register_port adc_port_props chk (.clock(clock),
   .rst_n(rst_n), .sclk(sclk), .din(din), .sdo(sdo),
   .result_valid(result_valid), .result(result), .mode_word(mode_word),
   .setup_word(setup_word), .switch_word(switch_word),
   .offset_word(offset_word), .gain_word(gain_word), .restart(restart),
   .part_reset(part_reset));

// [tb/host_serial_model.sv]
// serial master model of the host
`timescale 1ns/100ps
module host_serial_model (
   // serial pins
   output logic sclk,
   output logic din,
   input wire logic sdo
);
   logic idle_lo = 1'b0;
   initial begin
      sclk = 1'b1;
      din = 1'b1;
   end
   // msb first; sclk stands high between frames
   task automatic xfer(input logic [39:0] tx, input int n,
                       output logic [31:0] rx);
      rx = '0;
      for (int i = n - 1; i >= 0; i--) begin
         sclk = 1'b0;
         din = tx[i];
         #80;
         sclk = 1'b1;
         rx = {rx[30:0], sdo};
         #40;
         if (i == 0) begin
            din = ~idle_lo;
         end
         #40;
      end
   endtask
endmodule // host_serial_model

// [tb/adc_serial_register_port_tb.sv]
// self-checking bench of the converter serial register port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module adc_serial_register_port_tb;
   import adc_port_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic result_valid = 1'b0;
   conv_result_t result = '0;
   logic sclk, din, sdo, restart, part_reset;
   logic [23:0] mode_word, setup_word, offset_word, gain_word;
   logic [7:0] switch_word;
   logic [31:0] rx;
   int errors = 0, checked = 0, restarts = 0, resets = 0, cycles = 0;
   localparam logic [39:0] ONES = 40'hFF_FFFF_FFFF;
   adc_serial_register_port uut (.clock(clock), .rst_n(rst_n), .sclk(sclk),
      .din(din), .sdo(sdo), .result_valid(result_valid), .result(result),
      .mode_word(mode_word), .setup_word(setup_word),
      .switch_word(switch_word), .offset_word(offset_word),
      .gain_word(gain_word), .restart(restart), .part_reset(part_reset));
   host_serial_model host (.sclk(sclk), .din(din), .sdo(sdo));
   always #12.5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (restart === 1'b1) restarts++;
      if (part_reset === 1'b1) resets++;
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end
   task automatic stop_test;
      if (errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic clk(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   function automatic logic [23:0] word_of(input logic [2:0] a);
      case (a)
         ADDR_MODE: return mode_word;
         ADDR_CFG: return setup_word;
         ADDR_GPO: return {16'h0000, switch_word};
         ADDR_OFS: return offset_word;
         default: return gain_word;
      endcase
   endfunction
   task automatic wr(input logic [2:0] a, input logic [23:0] v, input int n);
      host.xfer(40'({2'b00, a, 3'b000}), 8, rx);
      host.xfer(40'(v), n, rx);
      clk(12);
   endtask
   task automatic rd(input logic [2:0] a, input int n);
      host.xfer(40'({2'b01, a, 3'b000}), 8, rx);
      host.xfer(40'h00_0000_0000, n, rx);
      clk(12);
   endtask
   task automatic post(input conv_result_t r);
      clk(1);
      result = r;
      result_valid = 1'b1;
      clk(1);
      result_valid = 1'b0;
      clk(3);
   endtask
   task automatic t_after_reset;
      `CHK("mode", MODE_RESET, mode_word)
      `CHK("setup", CFG_RESET, setup_word)
      `CHK("switch", GPO_RESET, switch_word)
      `CHK("offset", OFS_RESET, offset_word)
      `CHK("gain", GAIN_RESET, gain_word)
      `CHK("ready", 1'b1, sdo)
      rd(ADDR_CMD_STAT, 8);
      `CHK("status", STAT_RESET, rx[7:0])
   endtask
   task automatic t_regs;
      logic [2:0] a [5] = '{ADDR_MODE, ADDR_CFG, ADDR_GPO, ADDR_OFS, ADDR_GAIN};
      logic [23:0] v [5] = '{24'h08_0061, 24'h00_8155, 24'h00_0040,
                             24'h7F_FFF0, 24'h51_2340};
      int n;
      host.xfer(ONES, 39, rx);
      for (int i = 0; i < 5; i++) begin
         n = (a[i] == ADDR_GPO) ? 8 : 24;
         wr(a[i], v[i], n);
         `CHK("word", v[i], word_of(a[i]))
         rd(a[i], n);
         `CHK("readback", v[i], rx[23:0])
      end
      `CHK("restarts", 1, restarts)
      `CHK("part resets", 0, resets)
      wr(ADDR_ID, 24'h00_0000, 8);
      rd(ADDR_ID, 8);
      `CHK("id", PART_ID, rx[7:0])
   endtask
   task automatic t_data;
      conv_result_t r;
      r = '{data: 24'hA5_0F3C, chan: 3'h5, err: 1'b1, noref: 1'b0};
      post(r);
      `CHK("ready low", 1'b0, sdo)
      rd(ADDR_DATA, 24);
      `CHK("data", r.data, rx[23:0])
      `CHK("ready high", 1'b1, sdo)
      wr(ADDR_MODE, 24'h18_0061, 24);
      `CHK("restarts", 2, restarts)
      post(r);
      rd(ADDR_DATA, 32);
      `CHK("data status", {r.data, 4'h4, 1'b0, r.chan}, rx)
   endtask
   task automatic t_cont;
      conv_result_t r;
      host.idle_lo = 1'b1;
      host.xfer(40'(CMD_CONT_ENTER), 8, rx);
      for (int k = 0; k < 2; k++) begin
         r = '{data: 24'h13_579B ^ 24'(k), chan: 3'(k), err: 1'b0,
               noref: 1'b1};
         post(r);
         `CHK("cont ready", 1'b0, sdo)
         host.xfer(40'h00_0000_0000, 32, rx);
         `CHK("cont word", {r.data, 4'h2, 1'b0, r.chan}, rx)
         clk(12);
      end
      post(r);
      host.xfer(40'(CMD_CONT_EXIT), 8, rx);
      host.idle_lo = 1'b0;
      clk(12);
      `CHK("exit ready", 1'b0, sdo)
      rd(ADDR_CMD_STAT, 8);
      `CHK("status", {4'h2, 1'b0, r.chan}, rx[7:0])
   endtask
   task automatic t_forty;
      wr(ADDR_CFG, 24'h00_0255, 24);
      host.xfer(ONES, 40, rx);
      clk(12);
      `CHK("part resets", 1, resets)
      `CHK("setup", CFG_RESET, setup_word)
      `CHK("mode", MODE_RESET, mode_word)
      rd(ADDR_CFG, 24);
      `CHK("setup read", CFG_RESET, rx[23:0])
   endtask
   initial begin
      host.xfer(ONES, 13, rx);
      clk(1);
      rst_n = 1'b1;
      host.xfer(ONES, 6, rx);
      clk(2);
      t_after_reset();
      t_regs();
      t_data();
      t_cont();
      t_forty();
      stop_test();
   end
endmodule // adc_serial_register_port_tb
